// [pkg/umdp_pkg.sv]
// shared constants and types for the modem, dma and pin control block
package umdp_pkg;
  localparam int MSR_RI_BIT = 6;
  localparam int MSR_RI_FLAG_BIT = 2;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_LOOP_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_DMA_BIT = 3;
  localparam logic [7:0] MSR_RESET = 8'h00;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [6:0] RX_COUNT_RESET = 7'h00;
  localparam logic [6:0] RX_DEPTH = 7'h40;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam int TIMEOUT_CHARS = 4;
  localparam logic [15:0] CHAR_CYCLES = 16'h0010;
  localparam logic [15:0] TIMEOUT_CYCLES = 16'h0040;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam logic RTS_N_RESET = 1'b1;
  localparam logic TX_IDLE = 1'b1;
  localparam logic RECEIVE_DMA_REQUEST_N_RESET = 1'b1;
  localparam logic IRQ_RESET = 1'b0;
  typedef enum logic [1:0] {UMDP_DMA_IDLE, UMDP_DMA_ACTIVE} umdp_dma_state_t;
endpackage : umdp_pkg

// [pkg/umdp_flow_if.sv]
// signals between the top and its helper modules
`timescale 1ns/1ps
interface umdp_flow_if;
  logic [6:0] rx_count;
  logic [1:0] trig_sel;
  logic trig_hit;
  logic rx_push;
  logic timeout_hit;
  modport prov (input rx_count, input trig_sel, output trig_hit);
  modport user (output rx_count, output trig_sel, input trig_hit, output rx_push,
                input timeout_hit);
  modport tmo (input rx_count, input rx_push, output timeout_hit);
endinterface : umdp_flow_if

// [logic/umdp_trigger.sv]
// receive fifo trigger level compare
`timescale 1ns/1ps
module umdp_trigger (
  umdp_flow_if.prov fl
);
  logic [6:0] lvl;
  always_comb begin
    case (fl.trig_sel)
      2'h0: lvl = 7'h01;
      2'h1: lvl = 7'h10;
      2'h2: lvl = 7'h20;
      default: lvl = 7'h38;
    endcase
  end
  assign fl.trig_hit = (fl.rx_count >= lvl);
endmodule : umdp_trigger

// [logic/umdp_timeout.sv]
// character time-out counter for the receive fifo
`timescale 1ns/1ps
module umdp_timeout (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  umdp_flow_if.tmo fl
);
  typedef struct packed {
    logic [15:0] cnt;
    logic hit;
  } umdp_tmo_state_t;
  umdp_tmo_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    // data arriving or an empty fifo restarts the wait
    if (fl.rx_push || fl.rx_count == umdp_pkg::RX_COUNT_RESET) begin
      s_d.cnt = umdp_pkg::TIMEOUT_RESET;
      s_d.hit = 1'b0;
    end else if (s_q.cnt >= umdp_pkg::TIMEOUT_CYCLES - 16'h0001) begin
      s_d.hit = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign fl.timeout_hit = s_q.hit;
endmodule : umdp_timeout

// [logic/umdp_top.sv]
// modem status, request-to-send and receive dma request pin control
//
// Summary of operation
// - ring indicator level shown in status bit 6
// - status bit 2 set on ring rise
// - ring rise raises interrupt when enabled
// - rts follows control bit; high on reset/loopback
// - auto mode with fifo on: threshold logic forces rts inactive
// - fifo control bit 3 picks dma mode
// - non-fifo mode uses dma mode 0 only
// - mode 0 single transfers; mode 1 bursts
// - mode 0: request low while data held
// - mode 1: low on trigger/time-out, high empty
// - master reset drives serial output high
// - master reset high clears registers except status bit 6, drives rts, dma request and tx high, irq low
`timescale 1ns/1ps
module umdp_top (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic master_reset_i,
  input wire logic chip_select_i,
  input wire logic read_strobe_i,
  input wire logic read_strobe_n_i,
  input wire logic msr_select_i,
  input wire logic ring_n_i,
  input wire logic modem_int_en_i,
  input wire logic [7:0] modem_control_register_i,
  input wire logic mcr_write_i,
  input wire logic [7:0] fifo_control_register_i,
  input wire logic fcr_write_i,
  input wire logic auto_rts_en_i,
  input wire logic [1:0] trigger_sel_i,
  input wire logic rx_char_push_i,
  input wire logic rx_char_pop_i,
  input wire logic tx_serial_i,
  output logic [7:0] modem_status_register_o,
  output logic [7:0] modem_control_register_o,
  output logic [7:0] fifo_control_register_o,
  output logic [6:0] rx_count_o,
  output logic modem_irq_o,
  output logic rts_n_o,
  output logic receive_dma_request_n_o,
  output logic tx_o
);
  typedef struct packed {
    logic [7:0] modem_status_register;
    logic [7:0] modem_control_register;
    logic [7:0] fifo_control_register;
    logic [6:0] rx_count;
    logic ring_q;
    logic rd_q;
    logic irq;
    logic rts_n;
    logic receive_dma_request_n;
    logic tx;
    logic auto_hold;
    umdp_pkg::umdp_dma_state_t dma;
  } umdp_state_t;
  umdp_state_t s_q, s_d;
  umdp_flow_if fl ();
  logic read_now;
  logic msr_read;
  logic ring_rise;
  logic fifo_on;
  logic dma_mode1;
  logic push_ok;
  logic pop_ok;

  assign fl.rx_count = s_q.rx_count;
  assign fl.trig_sel = trigger_sel_i;
  assign fl.rx_push = push_ok;

  umdp_trigger u_trigger (
    .fl(fl)
  );

  umdp_timeout u_timeout (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .fl(fl)
  );

  // either polarity strobe reads; the idle one is held inactive by the host
  assign read_now = chip_select_i && (read_strobe_i || !read_strobe_n_i);
  // one clear per read, taken at the leading edge of the strobe
  assign msr_read = read_now && !s_q.rd_q && msr_select_i;
  // ring input is active low, so a low-to-high pin change is the rise
  assign ring_rise = ring_n_i && !s_q.ring_q;
  assign fifo_on = s_q.fifo_control_register[umdp_pkg::FCR_EN_BIT];
  assign dma_mode1 = fifo_on && s_q.fifo_control_register[umdp_pkg::FCR_DMA_BIT];
  // non-fifo mode behaves as a single holding register
  assign push_ok = rx_char_push_i && (fifo_on ? (s_q.rx_count < umdp_pkg::RX_DEPTH)
                                              : (s_q.rx_count == umdp_pkg::RX_COUNT_RESET));
  assign pop_ok = rx_char_pop_i && (s_q.rx_count != umdp_pkg::RX_COUNT_RESET);

  always_comb begin
    s_d = s_q;
    s_d.ring_q = ring_n_i;
    s_d.rd_q = read_now;
    s_d.tx = tx_serial_i;
    if (mcr_write_i) begin
      s_d.modem_control_register = modem_control_register_i;
    end
    if (fcr_write_i) begin
      s_d.fifo_control_register = fifo_control_register_i;
    end
    s_d.modem_status_register[umdp_pkg::MSR_RI_BIT] = !ring_n_i;
    // a rise that lands on the clearing read still sets the flag
    if (msr_read) begin
      s_d.modem_status_register[umdp_pkg::MSR_RI_FLAG_BIT] = 1'b0;
    end
    if (ring_rise) begin
      s_d.modem_status_register[umdp_pkg::MSR_RI_FLAG_BIT] = 1'b1;
    end
    s_d.irq = modem_int_en_i && s_d.modem_status_register[umdp_pkg::MSR_RI_FLAG_BIT];
    case ({push_ok, pop_ok})
      2'b10: s_d.rx_count = s_q.rx_count + 7'h01;
      2'b01: s_d.rx_count = s_q.rx_count - 7'h01;
      default: s_d.rx_count = s_q.rx_count;
    endcase
    // auto flow: drop at trigger, release only once empty
    // empty wins: the trigger compare still sees last cycle's count
    if (!auto_rts_en_i || !fifo_on) begin
      s_d.auto_hold = 1'b0;
    end else if (s_d.rx_count == umdp_pkg::RX_COUNT_RESET) begin
      s_d.auto_hold = 1'b0;
    end else if (fl.trig_hit) begin
      s_d.auto_hold = 1'b1;
    end
    s_d.rts_n = !s_d.modem_control_register[umdp_pkg::MCR_RTS_BIT] || s_d.modem_control_register[umdp_pkg::MCR_LOOP_BIT]
                || s_d.auto_hold;
    if (!dma_mode1) begin
      // single transfers: request whenever a character waits
      s_d.dma = umdp_pkg::UMDP_DMA_IDLE;
      s_d.receive_dma_request_n = (s_d.rx_count == umdp_pkg::RX_COUNT_RESET);
    end else begin
      case (s_q.dma)
        umdp_pkg::UMDP_DMA_IDLE: begin
          // a stale hit must not raise the request on a fifo just drained
          if ((fl.trig_hit || fl.timeout_hit)
              && s_d.rx_count != umdp_pkg::RX_COUNT_RESET) begin
            s_d.dma = umdp_pkg::UMDP_DMA_ACTIVE;
          end
        end
        umdp_pkg::UMDP_DMA_ACTIVE: begin
          // burst runs until empty
          if (s_d.rx_count == umdp_pkg::RX_COUNT_RESET) begin
            s_d.dma = umdp_pkg::UMDP_DMA_IDLE;
          end
        end
        default: s_d.dma = umdp_pkg::UMDP_DMA_IDLE;
      endcase
      s_d.receive_dma_request_n = (s_d.dma != umdp_pkg::UMDP_DMA_ACTIVE);
    end
    // master reset overrides everything else, synchronous to the clock
    if (master_reset_i) begin
      s_d.modem_status_register = umdp_pkg::MSR_RESET;
      s_d.modem_status_register[umdp_pkg::MSR_RI_BIT] = !ring_n_i;
      s_d.modem_control_register = umdp_pkg::MCR_RESET;
      s_d.fifo_control_register = umdp_pkg::FCR_RESET;
      s_d.rx_count = umdp_pkg::RX_COUNT_RESET;
      s_d.irq = umdp_pkg::IRQ_RESET;
      s_d.rts_n = umdp_pkg::RTS_N_RESET;
      s_d.receive_dma_request_n = umdp_pkg::RECEIVE_DMA_REQUEST_N_RESET;
      s_d.auto_hold = 1'b0;
      s_d.dma = umdp_pkg::UMDP_DMA_IDLE;
      s_d.tx = umdp_pkg::TX_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.modem_status_register <= umdp_pkg::MSR_RESET;
      s_q.modem_control_register <= umdp_pkg::MCR_RESET;
      s_q.fifo_control_register <= umdp_pkg::FCR_RESET;
      s_q.rx_count <= umdp_pkg::RX_COUNT_RESET;
      s_q.ring_q <= 1'b1;
      s_q.rd_q <= 1'b0;
      s_q.irq <= umdp_pkg::IRQ_RESET;
      s_q.rts_n <= umdp_pkg::RTS_N_RESET;
      s_q.receive_dma_request_n <= umdp_pkg::RECEIVE_DMA_REQUEST_N_RESET;
      s_q.tx <= umdp_pkg::TX_IDLE;
      s_q.auto_hold <= 1'b0;
      s_q.dma <= umdp_pkg::UMDP_DMA_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign modem_status_register_o = s_q.modem_status_register;
  assign modem_control_register_o = s_q.modem_control_register;
  assign fifo_control_register_o = s_q.fifo_control_register;
  assign rx_count_o = s_q.rx_count;
  assign modem_irq_o = s_q.irq;
  assign rts_n_o = s_q.rts_n;
  assign receive_dma_request_n_o = s_q.receive_dma_request_n;
  assign tx_o = s_q.tx;
endmodule : umdp_top

// [verif/umdp_top_assertions.sv]
// checker on the pin control block ports
`timescale 1ns/1ps
module umdp_top_assertions (
  input wire logic clk_sys_i, arst_n_i, master_reset_i, chip_select_i, read_strobe_i,
  input wire logic read_strobe_n_i, msr_select_i, ring_n_i, modem_int_en_i,
  input wire logic [1:0] trigger_sel_i,
  input wire logic [7:0] modem_status_register_o, modem_control_register_o,
  input wire logic [7:0] fifo_control_register_o,
  input wire logic [6:0] rx_count_o,
  input wire logic modem_irq_o, rts_n_o, receive_dma_request_n_o, tx_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  wire logic strobe = chip_select_i && (read_strobe_i || !read_strobe_n_i);
  wire logic m1 = fifo_control_register_o[0] && fifo_control_register_o[3];
  ring_level_a: assert property ($past(arst_n_i) |->
    modem_status_register_o[6] == !$past(ring_n_i)) else $error("ring level");
  ring_rise_a: assert property ($rose(ring_n_i) && !master_reset_i |=>
    modem_status_register_o[2]) else $error("ring flag");
  irq_follow_a: assert property (modem_int_en_i && $past(modem_int_en_i) |->
    modem_irq_o == modem_status_register_o[2]) else $error("irq");
  // only the first cycle of a read clears; a rise in that cycle wins
  read_clear_a: assert property (msr_select_i && strobe && !$past(strobe) && !$rose(ring_n_i)
    && !master_reset_i |=> !modem_status_register_o[2]) else $error("read clear");
  irq_off_a: assert property (!$past(modem_int_en_i) |-> !modem_irq_o)
    else $error("irq while disabled");
  rts_off_a: assert property (!modem_control_register_o[1] || modem_control_register_o[4]
    |-> rts_n_o) else $error("rts");
  dma_mode0_a: assert property (!m1 && $stable(m1) |->
    receive_dma_request_n_o == (rx_count_o == 7'h00)) else $error("mode 0");
  dma_empty_a: assert property (m1 && rx_count_o == 7'h00 |-> receive_dma_request_n_o)
    else $error("mode 1 empty");
  dma_trig_a: assert property (m1 && trigger_sel_i == 2'h1 && rx_count_o >= 7'h10
    ##1 rx_count_o != 7'h00 |-> !receive_dma_request_n_o) else $error("mode 1 trigger");
  master_reset_a: assert property (master_reset_i |=> rts_n_o && tx_o &&
    receive_dma_request_n_o && !modem_irq_o && rx_count_o == 7'h00) else $error("reset");
endmodule : umdp_top_assertions

// [verif/umdp_modem.sv]
// modem side model: ring indicator and received characters
`timescale 1ns/1ps
module umdp_modem (
  input wire logic clk_sys_i,
  output logic ring_n_o,
  output logic push_o
);
  initial begin
    ring_n_o = 1'b1;
    push_o = 1'b0;
  end
  task ring(input logic lvl);
    @(posedge clk_sys_i) ring_n_o <= lvl;
  endtask : ring
  // gap 0 gives a back to back burst, larger gaps a slow line
  task send(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_sys_i) push_o <= 1'b1;
      repeat (gap) @(posedge clk_sys_i) push_o <= 1'b0;
    end
    @(posedge clk_sys_i) push_o <= 1'b0;
  endtask : send
endmodule : umdp_modem

// [verif/test_uart_modem_dma_pin_control.sv]
// self-checking bench for the pin control block
`timescale 1ns/1ps
module test_uart_modem_dma_pin_control;
  logic clk_sys_i, arst_n_i, mrst, cs, rs, rs_n, msel, ring_n, int_en, mcr_wr, fcr_wr;
  logic auto_rts, push, pop, txs, irq, rts_n, rdy_n, tx;
  logic [7:0] mcr_d, fcr_d, modem_status_register, modem_control_register, fifo_control_register;
  logic [6:0] cnt;
  logic [1:0] trig;
  logic [8:0] rts_tab [4] = '{9'h002, 9'h112, 9'h100, 9'h002};
  logic [8:0] m0_tab [3] = '{9'h000, 9'h008, 9'h101};
  logic [8:0] lvl_tab [2] = '{9'h120, 9'h1b8};
  int fail_count = 0;
  int check_count = 0;
  umdp_top i_umdp_top (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .master_reset_i(mrst),
    .chip_select_i(cs), .read_strobe_i(rs), .read_strobe_n_i(rs_n), .msr_select_i(msel),
    .ring_n_i(ring_n), .modem_int_en_i(int_en), .modem_control_register_i(mcr_d),
    .mcr_write_i(mcr_wr), .fifo_control_register_i(fcr_d), .fcr_write_i(fcr_wr),
    .auto_rts_en_i(auto_rts), .trigger_sel_i(trig), .rx_char_push_i(push),
    .rx_char_pop_i(pop), .tx_serial_i(txs), .modem_status_register_o(modem_status_register),
    .modem_control_register_o(modem_control_register), .fifo_control_register_o(fifo_control_register), .rx_count_o(cnt),
    .modem_irq_o(irq), .rts_n_o(rts_n), .receive_dma_request_n_o(rdy_n), .tx_o(tx));
  umdp_modem i_umdp_modem (.clk_sys_i(clk_sys_i), .ring_n_o(ring_n), .push_o(push));
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic to_mcr, input logic [7:0] v);
    @(posedge clk_sys_i);
    mcr_d <= v;
    fcr_d <= v;
    mcr_wr <= to_mcr;
    fcr_wr <= !to_mcr;
    @(posedge clk_sys_i);
    mcr_wr <= 1'b0;
    fcr_wr <= 1'b0;
    #1;
  endtask : wr
  // hi picks the active-high strobe, otherwise the active-low one
  task rd(input logic hi);
    @(posedge clk_sys_i);
    cs <= 1'b1;
    rs <= hi;
    rs_n <= hi;
    @(posedge clk_sys_i);
    cs <= 1'b0;
    rs <= 1'b0;
    rs_n <= 1'b1;
    #1;
  endtask : rd
  task pop_n(input int n);
    repeat (n) @(posedge clk_sys_i) pop <= 1'b1;
    @(posedge clk_sys_i) pop <= 1'b0;
    #1;
  endtask : pop_n
  task give_verdict();
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    tick(3000);
    fail_count++;
    give_verdict();
  end
  initial begin
    {arst_n_i, mrst, cs, rs, int_en, mcr_wr, fcr_wr, auto_rts, pop} = '0;
    {rs_n, msel, txs, mcr_d, fcr_d, trig} = {3'b111, 16'h0000, 2'h1};
    tick(20);
    arst_n_i <= 1'b1;
    int_en <= 1'b1;
    auto_rts <= 1'b1;
    #1;
    chk({rts_n, tx, rdy_n, irq, modem_status_register}, 12'he00);
    i_umdp_modem.ring(1'b0);
    tick(2);
    #1;
    chk(modem_status_register, 8'h40);
    for (int i = 0; i < 2; i++) begin
      int_en <= !i[0];
      i_umdp_modem.ring(1'b0);
      i_umdp_modem.ring(1'b1);
      tick(2);
      #1;
      chk({irq, modem_status_register}, {!i[0], 8'h04});
      rd(i[0]);
      tick(1);
      #1;
      chk({irq, modem_status_register}, 9'h000);
    end
    foreach (rts_tab[i]) begin
      wr(1'b1, rts_tab[i][7:0]);
      chk(rts_n, rts_tab[i][8]);
    end
    wr(1'b0, 8'h09);
    i_umdp_modem.send(15, 1);
    tick(1);
    #1;
    chk({rts_n, rdy_n}, 2'b01);
    i_umdp_modem.send(1, 0);
    tick(1);
    #1;
    chk({rts_n, rdy_n, cnt}, {2'b10, 7'h10});
    pop_n(16);
    tick(1);
    #1;
    chk({rts_n, rdy_n, cnt}, {2'b01, 7'h00});
    i_umdp_modem.send(1, 0);
    tick(2);
    #1;
    chk(rdy_n, 1'b1);
    tick(70);
    #1;
    chk(rdy_n, 1'b0);
    pop_n(1);
    // the two deeper trigger levels, with back to back bursts
    foreach (lvl_tab[i]) begin
      trig <= lvl_tab[i][8:7];
      i_umdp_modem.send(lvl_tab[i][6:0] - 1, 0);
      tick(1);
      #1;
      chk({rts_n, rdy_n}, 2'b01);
      i_umdp_modem.send(1, 0);
      tick(1);
      #1;
      chk({rts_n, rdy_n, cnt}, {2'b10, lvl_tab[i][6:0]});
      pop_n(lvl_tab[i][6:0]);
    end
    trig <= 2'h0;
    foreach (m0_tab[i]) begin
      wr(1'b0, m0_tab[i][7:0]);
      i_umdp_modem.send(1, 0);
      tick(1);
      #1;
      chk({rts_n, rdy_n}, {m0_tab[i][8], 1'b0});
      pop_n(1);
      chk({rts_n, rdy_n}, 2'b01);
    end
    auto_rts <= 1'b0;
    i_umdp_modem.send(1, 0);
    tick(1);
    #1;
    chk({rts_n, rdy_n}, 2'b00);
    tick(1);
    mrst <= 1'b1;
    txs <= 1'b0;
    @(posedge clk_sys_i);
    mrst <= 1'b0;
    #1;
    chk({tx, rts_n, rdy_n, cnt, modem_control_register[1], fifo_control_register[0]}, {3'b111, 9'h000});
    tick(1);
    #1;
    chk(tx, 1'b0);
    give_verdict();
  end
endmodule : test_uart_modem_dma_pin_control
bind umdp_top umdp_top_assertions i_umdp_top_assertions (.*);
